// >>> rtl/scsd_pkg.sv
package scsd_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [31:0] DEFAULT_BASE    = 32'h2800_0000;
  localparam int          ADDR_W          = 32;
  // window size as log2 of bytes: 128KB = 2^17 .. 16MB = 2^24
  localparam logic [4:0]  SIZE_LOG2_MIN   = 5'h11;
  localparam logic [4:0]  SIZE_LOG2_MAX   = 5'h18;
  localparam logic [4:0]  SIZE_LOG2_RESET = 5'h18;
  localparam int          DATA_W          = 16;

  // ****************************************
  // wait states
  // ****************************************
  localparam int          WAIT_W          = 4;
  localparam logic [3:0]  WAIT_MAX        = 4'hf;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } scsd_access_t;

  typedef struct packed {
    logic [4:0]  size_log2;
    logic [3:0]  wait_states;
  } scsd_cfg_t;

endpackage

// >>> rtl/scsd_decoder.sv
// What this block does
// RULE1 - first window and module rom start at the default base address
// RULE2 - two separate active-low selects, one per module window
// RULE3 - module insertion resets the shared window size to sixteen megabytes
// RULE4 - second window starts right after the last first-window address
// RULE5 - each window is set up for a 16-bit data path
// RULE6 - module puts a 16-bit rom at the first window's lowest address
// RULE7 - window size is any power of two, 128KB to 16MB
// RULE8 - both windows always share one common size
// RULE9 - module removal raises an interrupt to the host
// RULE10 - module enters its own removal state; host cannot reach it
// RULE11 - module rom holds a valid identifying header
// RULE12 - after insertion use maximum wait states until header validated
// RULE13 - both windows use one identical wait-state count
// RULE14 - select only inside its window; never both selects at once
module scsd_decoder #(
  parameter logic [31:0] BASE_ADDR = scsd_pkg::DEFAULT_BASE
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // module presence pin, asynchronous
  input  wire logic                   module_present,
  // host access
  input  wire scsd_pkg::scsd_access_t host_access,
  // configuration from host software
  input  wire logic                   window_size_setting_we,
  input  wire logic [4:0]             window_size_setting,
  input  wire logic                   wait_setting_we,
  input  wire logic [3:0]             wait_setting,
  input  wire logic                   header_valid,
  // selects to the module
  output logic                        first_window_select_n,
  output logic                        second_window_select_n,
  // status to host
  output logic [31:0]                 window_base_query,
  output scsd_pkg::scsd_cfg_t         active_cfg,
  output logic                        bus_width_16,
  output logic                        removal_irq,
  output logic                        inserted
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // decode masks the address with the window size, so the base must sit on
  // the largest window boundary or the first window never matches at that size
  if (BASE_ADDR[23:0] != 24'h00_0000)
  begin : g_base_align
    $error("base must be aligned to the largest window");
  end
  // both windows at the largest size must fit below the top of memory
  if (BASE_ADDR > 32'hfe00_0000)
  begin : g_base_room
    $error("base leaves no room for two largest windows");
  end
  // reset size must be legal and shifts must stay inside 32 bits
  if ((scsd_pkg::SIZE_LOG2_RESET < scsd_pkg::SIZE_LOG2_MIN) ||
      (scsd_pkg::SIZE_LOG2_RESET > scsd_pkg::SIZE_LOG2_MAX) ||
      (scsd_pkg::SIZE_LOG2_MAX > 5'h1e))
  begin : g_size_range
    $error("window size constants out of range");
  end

  // ****************************************
  // presence synchroniser
  // ****************************************
  logic [2:0] pres_sync_r;
  logic       present_r;
  wire        pres_agree = (pres_sync_r[1] == pres_sync_r[2]);
  wire        pres_next  = pres_agree ? pres_sync_r[1] : present_r;
  wire        insert_evt = pres_next & ~present_r;
  wire        remove_evt = ~pres_next & present_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pres_sync_r <= 3'h0;
      present_r   <= 1'b0;
    end
    else
    begin
      pres_sync_r <= {pres_sync_r[1:0], module_present};
      present_r   <= pres_next;
    end
  end

  // ****************************************
  // shared configuration
  // ****************************************
  // one size and one wait count serve both windows, so no per-window state
  logic [4:0] size_log2_r;
  logic [4:0] size_log2_nxt;
  logic [3:0] wait_r;
  logic [3:0] wait_nxt;
  logic       hdr_ok_r;
  logic       hdr_ok_nxt;

  wire size_legal = (window_size_setting >= scsd_pkg::SIZE_LOG2_MIN) &&
                    (window_size_setting <= scsd_pkg::SIZE_LOG2_MAX);

  // a validation pulse counts only while a module is actually seated
  wire hdr_seen   = header_valid && present_r;
  wire size_wr_ok = window_size_setting_we && size_legal;
  wire wait_wr_ok = wait_setting_we && (hdr_ok_r || hdr_seen);

  always_comb
  begin
    size_log2_nxt = size_log2_r;
    wait_nxt      = wait_r;
    hdr_ok_nxt    = hdr_ok_r;
    if (insert_evt)
    begin
      size_log2_nxt = scsd_pkg::SIZE_LOG2_RESET; // RULE3
      wait_nxt      = scsd_pkg::WAIT_MAX;        // RULE12
      hdr_ok_nxt    = 1'b0;
    end
    else
    begin
      if (size_wr_ok)
        size_log2_nxt = window_size_setting;     // RULE7 RULE8
      if (hdr_seen)
        hdr_ok_nxt = 1'b1;
      // wait count only leaves maximum once header is validated
      if (wait_wr_ok)
        wait_nxt = wait_setting;                 // RULE12 RULE13
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      size_log2_r <= scsd_pkg::SIZE_LOG2_RESET;
    else
      size_log2_r <= size_log2_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      wait_r <= scsd_pkg::WAIT_MAX;
    else
      wait_r <= wait_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      hdr_ok_r <= 1'b0;
    else
      hdr_ok_r <= hdr_ok_nxt;
  end

  // ****************************************
  // window decode
  // ****************************************
  function automatic logic [31:0] win_bytes(input logic [4:0] lg);
    win_bytes = 32'h0000_0001 << lg;
  endfunction

  function automatic logic [31:0] size_mask(input logic [4:0] lg);
    size_mask = ~(win_bytes(lg) - 32'h0000_0001);
  endfunction

  // one compare serves both windows so the two decodes cannot drift apart
  function automatic logic in_window(
    input logic [31:0] addr,
    input logic [31:0] base,
    input logic [31:0] msk
  );
    in_window = ((addr & msk) == base);
  endfunction

  wire [31:0] win_size    = win_bytes(size_log2_r);
  wire [31:0] mask        = size_mask(size_log2_r);
  wire [31:0] second_base = BASE_ADDR + win_size;                  // RULE4
  wire        req_live    = host_access.valid && present_r;
  wire        in_first    = in_window(host_access.addr, BASE_ADDR, mask);
  wire        in_second   = in_window(host_access.addr, second_base, mask);
  wire        hit_first   = req_live && in_first;                  // RULE1
  wire        hit_second  = req_live && !hit_first && in_second;   // RULE14

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      first_window_select_n  <= 1'b1;
      second_window_select_n <= 1'b1;
    end
    else
    begin
      first_window_select_n  <= ~hit_first;      // RULE2 RULE14
      second_window_select_n <= ~hit_second;     // RULE2 RULE14
    end
  end

  // status mirrors the shared config a cycle late; selects never wait on it
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      window_base_query <= BASE_ADDR;
      active_cfg        <= '{size_log2: scsd_pkg::SIZE_LOG2_RESET,
                             wait_states: scsd_pkg::WAIT_MAX};
      bus_width_16      <= 1'b1;
    end
    else
    begin
      window_base_query <= BASE_ADDR;                            // RULE1
      active_cfg        <= '{size_log2: size_log2_r, wait_states: wait_r};
      bus_width_16      <= 1'b1;                                 // RULE5
    end
  end

  // removal pulse and debounced presence
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      removal_irq <= 1'b0;
      inserted    <= 1'b0;
    end
    else
    begin
      removal_irq <= remove_evt;                                 // RULE9
      inserted    <= present_r;
    end
  end

endmodule // scsd_decoder

// >>> verification/scsd_card.sv
module scsd_card (
  // slot pins
  input  wire logic        plug,
  input  wire logic        first_window_select_n,
  input  wire logic [31:0] addr,
  output logic             module_present,
  output logic [15:0]      rom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // header marker then version; values are arbitrary, no real product code
  localparam logic [15:0] HDR_WORDS [4] = '{16'h5a3c, 16'h0001,
                                            16'h0000, 16'hffff};
  // the card alone owns its pin on removal, host cannot reach it
  assign module_present = plug;
  // 16-bit rom at the lowest first-window address; idle bus reads high
  wire [15:0] rom_word = HDR_WORDS[addr[2:1]];
  assign rom_data = first_window_select_n ? 16'hffff : rom_word;
endmodule // scsd_card

// >>> verification/scsd_chk_checker.sv
module scsd_chk #(
  parameter logic [31:0] BASE_ADDR = scsd_pkg::DEFAULT_BASE
) (
  // watched
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire scsd_pkg::scsd_access_t host_access,
  input wire logic                   first_window_select_n,
  input wire logic                   second_window_select_n,
  input wire logic [31:0]            window_base_query,
  input wire scsd_pkg::scsd_cfg_t    active_cfg,
  input wire logic                   removal_irq,
  input wire logic                   inserted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  one_sel_a: assert property (
    first_window_select_n || second_window_select_n) else $error("both");
  base_fix_a: assert property (
    window_base_query == BASE_ADDR) else $error("base");
  rom_hit_a: assert property (
    host_access.valid && inserted && host_access.addr[31:17] ==
    BASE_ADDR[31:17] |=> !first_window_select_n || !inserted)
    else $error("rom");
  first_in_a: assert property (
    !first_window_select_n |-> $past(host_access.valid) &&
    $past(host_access.addr[31:24]) == BASE_ADDR[31:24]) else $error("sel0");
  second_in_a: assert property (
    !second_window_select_n |-> $past(host_access.valid) &&
    $past(host_access.addr[31:25]) == BASE_ADDR[31:25] &&
    $past(host_access.addr[31:17]) != BASE_ADDR[31:17]) else $error("sel1");
  irq_once_a: assert property (
    removal_irq |=> !removal_irq) else $error("irq");
  ins_cfg_a: assert property (
    $rose(inserted) |-> active_cfg == 9'h18f) else $error("ins");
  size_ok_a: assert property (
    active_cfg.size_log2 inside {[5'h11:5'h18]}) else $error("size");
endmodule // scsd_chk

bind scsd_decoder scsd_chk #(
  .BASE_ADDR(BASE_ADDR)
) u_chk (
  .core_clk               (core_clk),
  .rst                    (rst),
  .host_access            (host_access),
  .first_window_select_n  (first_window_select_n),
  .second_window_select_n (second_window_select_n),
  .window_base_query      (window_base_query),
  .active_cfg             (active_cfg),
  .removal_irq            (removal_irq),
  .inserted               (inserted)
);

// >>> verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, rst = 1'h1, plug = 1'h0, module_present, got;
  logic window_size_setting_we = 1'h0, wait_setting_we = 1'h0;
  logic header_valid = 1'h0, first_window_select_n, second_window_select_n;
  logic [4:0] window_size_setting = 5'h18;
  logic [3:0] wait_setting = 4'h0;
  logic [31:0] window_base_query;
  logic bus_width_16, removal_irq, inserted;
  logic [15:0] rom_data;
  scsd_pkg::scsd_access_t host_access = '0;
  scsd_pkg::scsd_cfg_t active_cfg;
  int bad_count = 0, cmp_count = 0;
  wire logic [1:0] sel = {first_window_select_n, second_window_select_n};
  // size, address, expected {first, second} select
  logic [38:0] rows [12] = '{
    {5'h18, 32'h2800_0000, 2'h1}, {5'h18, 32'h28ff_ffff, 2'h1},
    {5'h18, 32'h2900_0000, 2'h2}, {5'h18, 32'h29ff_ffff, 2'h2},
    {5'h18, 32'h2a00_0000, 2'h3}, {5'h18, 32'h27ff_ffff, 2'h3},
    {5'h14, 32'h280f_ffff, 2'h1}, {5'h14, 32'h2810_0000, 2'h2},
    {5'h14, 32'h281f_ffff, 2'h2}, {5'h14, 32'h2820_0000, 2'h3},
    {5'h11, 32'h2801_ffff, 2'h1}, {5'h11, 32'h2804_0000, 2'h3}};
  scsd_decoder dut (
    .core_clk               (core_clk),
    .rst                    (rst),
    .module_present         (module_present),
    .host_access            (host_access),
    .window_size_setting_we (window_size_setting_we),
    .window_size_setting    (window_size_setting),
    .wait_setting_we        (wait_setting_we),
    .wait_setting           (wait_setting),
    .header_valid           (header_valid),
    .first_window_select_n  (first_window_select_n),
    .second_window_select_n (second_window_select_n),
    .window_base_query      (window_base_query),
    .active_cfg             (active_cfg),
    .bus_width_16           (bus_width_16),
    .removal_irq            (removal_irq),
    .inserted               (inserted)
  );
  scsd_card card (
    .plug                  (plug),
    .first_window_select_n (first_window_select_n),
    .addr                  (host_access.addr),
    .module_present        (module_present),
    .rom_data              (rom_data)
  );
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(logic [31:0] a);
    @(posedge core_clk) host_access <= '{1'h1, a};
    @(posedge core_clk) host_access.valid <= 1'h0;
    #1;
  endtask
  task automatic wr(logic [4:0] v);
    @(posedge core_clk) window_size_setting <= v;
    window_size_setting_we <= 1'h1;
    @(posedge core_clk) window_size_setting_we <= 1'h0;
  endtask
  task automatic cfgw(logic h);
    @(posedge core_clk) {header_valid, wait_setting_we} <= {h, 1'h1};
    wait_setting <= 4'h3;
    @(posedge core_clk) {header_valid, wait_setting_we} <= 2'h0;
    @(posedge core_clk) #1;
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // ****************
  // scenarios
  // ****************
  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    #1 chk("cfg", active_cfg, 9'h18f);
    acc(32'h2800_0000);
    chk("sel", sel, 2'h3);
    @(posedge core_clk) plug <= 1'h1;
    repeat (8) @(posedge core_clk);
    #1 chk("ins", inserted, 1'h1);
    chk("base", window_base_query, scsd_pkg::DEFAULT_BASE);
    chk("width", bus_width_16, 1'h1);
    acc(32'h2800_0000);
    chk("sel", sel, 2'h1);
    chk("rom hdr", rom_data, 16'h5a3c);
    $display("reset done");
    foreach (rows[i])
    begin
      wr(rows[i][38:34]);
      acc(rows[i][33:2]);
      chk("sel", sel, rows[i][1:0]);
      chk("size", active_cfg.size_log2, rows[i][38:34]);
    end
    wr(5'h10);
    acc(32'h2802_0000);
    chk("bad size", active_cfg.size_log2, 5'h11);
    chk("sel", sel, 2'h2);
    cfgw(1'h0);
    chk("wait", active_cfg.wait_states, 4'hf);
    cfgw(1'h1);
    chk("wait", active_cfg.wait_states, 4'h3);
    $display("config done");
    @(posedge core_clk) plug <= 1'h0;
    got = 1'h0;
    repeat (8)
    begin
      @(posedge core_clk) #1;
      got = got | removal_irq;
    end
    chk("irq", got, 1'h1);
    chk("ins", inserted, 1'h0);
    acc(32'h2800_0000);
    chk("sel", sel, 2'h3);
    @(posedge core_clk) plug <= 1'h1;
    repeat (8) @(posedge core_clk);
    #1 chk("cfg", active_cfg, 9'h18f);
    $display("removal done");
    wr(5'h14);
    @(posedge core_clk) rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    #1 chk("rst ins", inserted, 1'h0);
    chk("rst sel", sel, 2'h3);
    repeat (8) @(posedge core_clk);
    #1 chk("rst cfg", active_cfg, 9'h18f);
    chk("rst ins", inserted, 1'h1);
    $display("mid reset done");
    print_verdict();
  end
endmodule // tb
